// ---- src/adc_cfg_map.vh ----
// register map, field positions, reset values and timing for the
// converter configuration block; assumes a 200 MHz register clock
`ifndef ADC_CFG_MAP_VH
`define ADC_CFG_MAP_VH

// register indexes; byte address is four times the index
`define IDX_MODE_CONTROL    8'h02
`define IDX_CLOCK_CONFIG    8'h03
`define IDX_GAIN_FIRST      8'h04
`define IDX_IRQ_STATUS      8'h08
`define IDX_IRQ_MASK        8'h09

// reset values
`define RST_MODE_CONTROL    16'h0510
`define RST_CLOCK_CONFIG    16'h7F0E
`define RST_GAIN_FIRST      16'h0000
`define RST_IRQ_MASK        7'h00

// mode register fields
`define MODE_SEL_HI         3
`define MODE_SEL_LO         2
`define MODE_FLOAT_BIT      1
`define MODE_FMT_BIT        0

// clock register fields
`define CLK_WMASK           16'h3FFF
`define CLK_EN_HI           13
`define CLK_EN_LO           8
`define CLK_XTAL_OFF_BIT    7
`define CLK_EXTREF_BIT      6
`define CLK_RATIO_HI        4
`define CLK_RATIO_LO        2
`define CLK_POWER_HI        1
`define CLK_POWER_LO        0

// gain register fields
`define GAIN_CH3_HI         14
`define GAIN_CH3_LO         12
`define GAIN_CH2_HI         10
`define GAIN_CH2_LO         8
`define GAIN_CH1_HI         6
`define GAIN_CH1_LO         4
`define GAIN_CH0_HI         2
`define GAIN_CH0_LO         0

// interrupt status: bits 5:0 channel done, bit 6 ready asserted
`define IRQ_READY_BIT       6

// ready pulse cycles: 20 ns at 5 ns per cycle
`define READY_PULSE_CYCLES  3'h4

// bus responses
`define RESP_OKAY           2'h0
`define RESP_SLVERR         2'h2

`endif

// ---- src/sync_two_ff.v ----
// two flip-flop synchroniser for a group of level inputs
// assumes the inputs are slow levels from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module sync_two_ff #(
   parameter WIDTH = 6
) (
   // clock and reset
   input  wire             ref_clk_in,
   input  wire             arst_n_in,
   // levels
   input  wire [WIDTH-1:0] async_in,
   output wire [WIDTH-1:0] sync_out
);
   reg [WIDTH-1:0] meta_reg;
   reg [WIDTH-1:0] stable_reg;

   // first stage is read by the second stage only
   always @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         meta_reg   <= {WIDTH{1'b0}};
         stable_reg <= {WIDTH{1'b0}};
      end else begin
         meta_reg   <= async_in;
         stable_reg <= meta_reg;
      end
   end

   assign sync_out = stable_reg;
endmodule
`default_nettype wire

// ---- src/ready_pin_driver.v ----
// conversion ready pin driver: pending flags, source select, pulse
// assumes channel levels are already synchronised to ref_clk_in
`timescale 1ns/1ps
`default_nettype none
`include "adc_cfg_map.vh"
module ready_pin_driver (
   // clock and reset
   input  wire       ref_clk_in,
   input  wire       arst_n_in,
   // configuration
   input  wire [5:0] chan_enable_in,
   input  wire [1:0] ready_source_select_in,
   input  wire       ready_idle_float_in,
   input  wire       ready_pulse_format_in,
   // channel activity
   input  wire [5:0] chan_level_in,
   input  wire [5:0] chan_done_in,
   input  wire       data_read_in,
   // pin and event
   output reg        ready_pin_out,
   output reg        ready_pin_oe_out,
   output wire       ready_event_out
);
   localparam [2:0] PULSE_LEN = `READY_PULSE_CYCLES;

   reg  [5:0] pending_reg;
   reg        avail_prev_reg;
   reg  [2:0] pulse_cnt_reg;
   reg        avail;
   wire [5:0] live_pend;
   wire       avail_rise;
   wire       drive_low;

   // disabled channels never count as pending
   assign live_pend = pending_reg & chan_enable_in; // RULE16

   // source select; lagging waits for every enabled channel
   always @* begin
      case (ready_source_select_in) // RULE1
         2'h0:    avail = (&(live_pend | ~chan_enable_in)) &
                          (|chan_enable_in);
         2'h1:    avail = |(chan_level_in & chan_enable_in);
         default: avail = |live_pend;
      endcase
   end

   assign avail_rise      = avail & ~avail_prev_reg;
   assign ready_event_out = avail_rise;
   // held low while available, or only for the fixed pulse
   assign drive_low = ready_pulse_format_in ? (pulse_cnt_reg != 3'h0)
                                            : avail; // RULE3

   // pending flags: a new result beats a simultaneous data read
   always @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         pending_reg    <= 6'h00;
         avail_prev_reg <= 1'b0;
         pulse_cnt_reg  <= 3'h0;
      end else begin
         pending_reg    <= ((data_read_in ? 6'h00 : pending_reg) |
                            chan_done_in) & chan_enable_in;
         avail_prev_reg <= avail;
         if (avail_rise)
            pulse_cnt_reg <= PULSE_LEN; // RULE3
         else if (pulse_cnt_reg != 3'h0)
            pulse_cnt_reg <= pulse_cnt_reg - 3'h1;
      end
   end

   // pin registered; idle is high or released by the float bit
   always @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         ready_pin_out    <= 1'b1;
         ready_pin_oe_out <= 1'b1;
      end else begin
         ready_pin_out    <= ~drive_low;
         ready_pin_oe_out <= drive_low | ~ready_idle_float_in; // RULE2
      end
   end
endmodule
`default_nettype wire

// ---- src/adc_channel_config_registers.v ----
// configuration registers of a six channel converter on AXI4-Lite
// assumes channel done levels arrive asynchronously from the modulators
//
// Function
// RULE1: ready pin source: 00 most lagging, 01 OR of enabled, else leading.
// RULE2: idle pin driven high, or released when the float bit is set.
// RULE3: available data drives pin low, held or fixed-length low pulse.
// RULE4: six channel enables at bits 13:8, all enabled after reset.
// RULE5: clock register bits 15:14 are read-only and read as zero; the 7F0Eh reset value sets bit 14 until the first write.
// RULE6: bit 7 set turns the crystal oscillator off, reset keeps it on.
// RULE7: bit 6 set selects external reference, reset selects internal one.
// RULE8: bits 4:2 pick oversampling 128 up to 16256, reset code 011.
// RULE9: bits 1:0 pick power mode, 1x high resolution, reset 10.
// RULE10: clock register sits at index 03h, resets to 7F0Eh.
// RULE11: gain codes ch3 at 14:12, ch2 at 10:8, gains 1 to 128.
// RULE12: first gain register sits at index 4h, resets to 0000h.
// RULE13: software writes zero to the reserved clock and gain bits.
// RULE14: mode register at index 02h, reset 0510h, ready controls bits 3:0.
// RULE15: gain codes ch1 at bits 6:4 and ch0 at bits 2:0.
// RULE16: fields read back as written; disabled channels ignored for ready.
`timescale 1ns/1ps
`default_nettype none
`include "adc_cfg_map.vh"
module adc_channel_config_registers (
   // clock and reset
   input  wire        ref_clk_in,
   input  wire        arst_n_in,
   // axi4-lite write address
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   input  wire [7:0]  s_axi_awaddr,
   // axi4-lite write data
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   // axi4-lite write response
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   output reg  [1:0]  s_axi_bresp,
   // axi4-lite read
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   input  wire [7:0]  s_axi_araddr,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   // converter side
   input  wire [5:0]  channel_done_in,
   input  wire        data_read_in,
   // conversion ready pin
   output wire        conversion_ready_pin_out,
   output wire        conversion_ready_pin_oe_out,
   // configuration outputs
   output wire [5:0]  channel_enable_out,
   output wire        crystal_osc_off_out,
   output wire        external_reference_on_out,
   output wire [2:0]  oversampling_ratio_out,
   output reg  [13:0] oversampling_factor_out,
   output reg  [1:0]  power_mode_select_out,
   output wire [2:0]  gain_code_ch0_out,
   output wire [2:0]  gain_code_ch1_out,
   output wire [2:0]  gain_code_ch2_out,
   output wire [2:0]  gain_code_ch3_out,
   // interrupt
   output wire        irq_out
);
   reg  [15:0] mode_control_reg;
   reg  [15:0] clock_channel_config_reg;
   reg  [15:0] gain_select_first_reg;
   reg  [6:0]  irq_status_reg;
   reg  [6:0]  irq_mask_reg;
   reg         aw_hold_reg;
   reg  [7:0]  awaddr_reg;
   reg         w_hold_reg;
   reg  [31:0] wdata_reg;
   reg  [3:0]  wstrb_reg;
   reg  [5:0]  level_prev_reg;
   reg  [31:0] rdata_next;
   reg         rvalid_map;
   wire [5:0]  chan_level;
   wire [5:0]  chan_done;
   wire        ready_event;
   wire        do_write;
   wire        do_read;
   wire [7:0]  w_idx;
   wire [7:0]  r_idx;
   wire        status_read;
   wire [6:0]  irq_events;

   // byte address to register index; low two bits ignored
   function [7:0] reg_index;
      input [7:0] byte_addr;
      begin
         reg_index = {2'h0, byte_addr[7:2]};
      end
   endfunction

   // apply the two low byte lanes to a 16-bit register
   function [15:0] merge_lanes;
      input [15:0] old_val;
      input [31:0] new_val;
      input [3:0]  strb;
      begin
         merge_lanes[7:0]  = strb[0] ? new_val[7:0]  : old_val[7:0];
         merge_lanes[15:8] = strb[1] ? new_val[15:8] : old_val[15:8];
      end
   endfunction

   // channel done levels come from the analog side
   sync_two_ff #(
      .WIDTH (6)
   ) u_done_sync (
      .ref_clk_in (ref_clk_in),
      .arst_n_in  (arst_n_in),
      .async_in   (channel_done_in),
      .sync_out   (chan_level)
   );

   // rising edge of a synchronised done level marks a new result
   always @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in)
         level_prev_reg <= 6'h00;
      else
         level_prev_reg <= chan_level;
   end
   assign chan_done = chan_level & ~level_prev_reg;

   ready_pin_driver u_ready (
      .ref_clk_in             (ref_clk_in),
      .arst_n_in              (arst_n_in),
      .chan_enable_in         (channel_enable_out),
      .ready_source_select_in (mode_control_reg[`MODE_SEL_HI:`MODE_SEL_LO]),
      .ready_idle_float_in    (mode_control_reg[`MODE_FLOAT_BIT]),
      .ready_pulse_format_in  (mode_control_reg[`MODE_FMT_BIT]),
      .chan_level_in          (chan_level),
      .chan_done_in           (chan_done),
      .data_read_in           (data_read_in),
      .ready_pin_out          (conversion_ready_pin_out),
      .ready_pin_oe_out       (conversion_ready_pin_oe_out),
      .ready_event_out        (ready_event)
   );

   // write channel: address and data may come in either order
   assign s_axi_awready = ~aw_hold_reg;
   assign s_axi_wready  = ~w_hold_reg;
   assign do_write      = aw_hold_reg & w_hold_reg & ~s_axi_bvalid;
   assign w_idx         = reg_index(awaddr_reg);

   always @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         aw_hold_reg  <= 1'b0;
         awaddr_reg   <= 8'h00;
         w_hold_reg   <= 1'b0;
         wdata_reg    <= 32'h00000000;
         wstrb_reg    <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `RESP_OKAY;
      end else begin
         if (s_axi_awvalid && !aw_hold_reg) begin
            aw_hold_reg <= 1'b1;
            awaddr_reg  <= s_axi_awaddr;
         end
         if (s_axi_wvalid && !w_hold_reg) begin
            w_hold_reg <= 1'b1;
            wdata_reg  <= s_axi_wdata;
            wstrb_reg  <= s_axi_wstrb;
         end
         if (do_write) begin
            aw_hold_reg  <= 1'b0;
            w_hold_reg   <= 1'b0;
            s_axi_bvalid <= 1'b1;
            case (w_idx)
               `IDX_MODE_CONTROL, `IDX_CLOCK_CONFIG, `IDX_GAIN_FIRST,
               `IDX_IRQ_STATUS, `IDX_IRQ_MASK:
                  s_axi_bresp <= `RESP_OKAY;
               default:
                  s_axi_bresp <= `RESP_SLVERR;
            endcase
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // configuration registers; reserved bits are stored as written
   always @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         mode_control_reg         <= `RST_MODE_CONTROL; // RULE14
         clock_channel_config_reg <= `RST_CLOCK_CONFIG; // RULE10 RULE4
         gain_select_first_reg    <= `RST_GAIN_FIRST; // RULE12
         irq_mask_reg             <= `RST_IRQ_MASK;
      end else if (do_write) begin
         case (w_idx)
            `IDX_MODE_CONTROL:
               mode_control_reg <= merge_lanes(mode_control_reg,
                                               wdata_reg, wstrb_reg);
            // top two bits are cleared by every write
            `IDX_CLOCK_CONFIG:
               clock_channel_config_reg <= merge_lanes(
                  clock_channel_config_reg, wdata_reg, wstrb_reg) &
                  `CLK_WMASK; // RULE5 RULE16
            `IDX_GAIN_FIRST:
               gain_select_first_reg <= merge_lanes(gain_select_first_reg,
                                                    wdata_reg, wstrb_reg);
            `IDX_IRQ_MASK:
               if (wstrb_reg[0])
                  irq_mask_reg <= wdata_reg[6:0];
            default: ;
         endcase
      end
   end

   // read channel: one read outstanding, data registered
   assign s_axi_arready = ~s_axi_rvalid;
   assign do_read       = s_axi_arvalid & ~s_axi_rvalid;
   assign r_idx         = reg_index(s_axi_araddr);
   assign status_read   = do_read & (r_idx == `IDX_IRQ_STATUS);

   // read mux; fields return the last value written
   always @* begin
      rdata_next = 32'h00000000;
      rvalid_map = 1'b1;
      case (r_idx)
         `IDX_MODE_CONTROL: rdata_next[15:0] = mode_control_reg;
         `IDX_CLOCK_CONFIG: rdata_next[15:0] = clock_channel_config_reg;
         `IDX_GAIN_FIRST:   rdata_next[15:0] = gain_select_first_reg;
         `IDX_IRQ_STATUS:   rdata_next[6:0]  = irq_status_reg;
         `IDX_IRQ_MASK:     rdata_next[6:0]  = irq_mask_reg;
         default:           rvalid_map       = 1'b0;
      endcase
   end

   always @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h00000000;
         s_axi_rresp  <= `RESP_OKAY;
      end else if (do_read) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rdata_next;
         s_axi_rresp  <= rvalid_map ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // sticky status; an event in the clearing cycle survives the read
   assign irq_events = {ready_event, chan_done & channel_enable_out};
   always @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in)
         irq_status_reg <= 7'h00;
      else
         irq_status_reg <= (status_read ? 7'h00 : irq_status_reg) |
                           irq_events;
   end
   assign irq_out = |(irq_status_reg & irq_mask_reg);

   // field outputs straight from the registers
   assign channel_enable_out =
      clock_channel_config_reg[`CLK_EN_HI:`CLK_EN_LO]; // RULE4
   assign crystal_osc_off_out =
      clock_channel_config_reg[`CLK_XTAL_OFF_BIT]; // RULE6
   assign external_reference_on_out =
      clock_channel_config_reg[`CLK_EXTREF_BIT]; // RULE7
   assign oversampling_ratio_out =
      clock_channel_config_reg[`CLK_RATIO_HI:`CLK_RATIO_LO]; // RULE8
   assign gain_code_ch3_out =
      gain_select_first_reg[`GAIN_CH3_HI:`GAIN_CH3_LO]; // RULE11
   assign gain_code_ch2_out =
      gain_select_first_reg[`GAIN_CH2_HI:`GAIN_CH2_LO]; // RULE11
   assign gain_code_ch1_out =
      gain_select_first_reg[`GAIN_CH1_HI:`GAIN_CH1_LO]; // RULE15
   assign gain_code_ch0_out =
      gain_select_first_reg[`GAIN_CH0_HI:`GAIN_CH0_LO]; // RULE15

   // decoded ratio and power mode; the top ratio is not a power of two
   always @* begin
      case (oversampling_ratio_out) // RULE8
         3'h0:    oversampling_factor_out = 14'h0080;
         3'h1:    oversampling_factor_out = 14'h0100;
         3'h2:    oversampling_factor_out = 14'h0200;
         3'h3:    oversampling_factor_out = 14'h0400;
         3'h4:    oversampling_factor_out = 14'h0800;
         3'h5:    oversampling_factor_out = 14'h1000;
         3'h6:    oversampling_factor_out = 14'h2000;
         default: oversampling_factor_out = 14'h3F80;
      endcase
      // both upper codes mean high resolution
      case (clock_channel_config_reg[`CLK_POWER_HI:`CLK_POWER_LO]) // RULE9
         2'h0:    power_mode_select_out = 2'h0;
         2'h1:    power_mode_select_out = 2'h1;
         default: power_mode_select_out = 2'h2;
      endcase
   end
endmodule
`default_nettype wire

// ---- testbench/modulator_model.sv ----
// behavioural converter modulators giving per-channel result levels
// assumes kicks on one channel at least 12 cycles apart
`timescale 1ns/1ps
`default_nettype none
module modulator_model (
   // clock and reset
   input  wire        ref_clk_in,
   input  wire        arst_n_in,
   // stimulus and levels
   input  wire  [5:0] kick_in,
   output logic [5:0] done_out
);
   logic [2:0] cnt_reg [0:5];
   integer     i;
   // six cycles high; sync needs three
   always @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         done_out <= 6'h00;
         for (i = 0; i < 6; i = i + 1) cnt_reg[i] <= 3'h0;
      end else begin
         for (i = 0; i < 6; i = i + 1) begin
            if (kick_in[i]) begin
               done_out[i] <= 1'b1;
               cnt_reg[i]  <= 3'h6;
            end else if (cnt_reg[i] != 3'h0) begin
               cnt_reg[i]  <= cnt_reg[i] - 3'h1;
               done_out[i] <= (cnt_reg[i] != 3'h1);
            end
         end
      end
   end
endmodule
`default_nettype wire

// ---- testbench/adc_cfg_chk.sv ----
// port checker for the converter configuration registers
// assumes one clock domain
`timescale 1ns/1ps
`default_nettype none
`include "adc_cfg_map.vh"
module adc_cfg_chk (
   // clock and reset
   input wire        ref_clk_in,
   input wire        arst_n_in,
   // bus
   input wire        s_axi_awvalid,
   input wire        s_axi_awready,
   input wire        s_axi_wvalid,
   input wire        s_axi_wready,
   input wire        s_axi_bvalid,
   input wire        s_axi_bready,
   input wire [1:0]  s_axi_bresp,
   input wire        s_axi_arvalid,
   input wire        s_axi_arready,
   input wire        s_axi_rvalid,
   input wire        s_axi_rready,
   input wire [31:0] s_axi_rdata,
   input wire [1:0]  s_axi_rresp,
   // pin and configuration
   input wire        conversion_ready_pin_out,
   input wire        conversion_ready_pin_oe_out,
   input wire [2:0]  oversampling_ratio_out,
   input wire [13:0] oversampling_factor_out,
   input wire [1:0]  power_mode_select_out
);
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!arst_n_in);
   // write taken in one edge, answered two edges later
   sequence s_wr_take;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_wr_ans;
      !s_axi_bvalid ##1 s_axi_bvalid;
   endsequence
   AST_WR_LATENCY: assert property (s_wr_take |=> s_wr_ans)
      else $error("write answer late or early");
   AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   AST_AR_GATE: assert property (s_axi_arready == !s_axi_rvalid)
      else $error("read address ready wrong");
   AST_RD_LATENCY: assert property (s_axi_arvalid && s_axi_arready
      |=> s_axi_rvalid)
      else $error("read answer late");
   AST_ERR_ZERO: assert property (s_axi_rvalid
      && s_axi_rresp == `RESP_SLVERR |-> s_axi_rdata == 32'h0)
      else $error("error read carries data");
   AST_OSR_DECODE: assert property (oversampling_factor_out ==
      (oversampling_ratio_out == 3'h7 ? 14'h3F80
       : 14'h0080 << oversampling_ratio_out))
      else $error("oversampling factor wrong");
   AST_PWR_RANGE: assert property (power_mode_select_out != 2'h3)
      else $error("power mode code three seen");
   AST_LOW_DRIVEN: assert property (!conversion_ready_pin_out
      |-> conversion_ready_pin_oe_out)
      else $error("ready low while released");
endmodule
bind adc_channel_config_registers adc_cfg_chk u_chk (.*);
`default_nettype wire

// ---- testbench/adc_channel_config_registers_tb_top.sv ----
// self-checking bench: registers over AXI4-Lite, ready pin, interrupt
// assumes the checker is bound in
`timescale 1ns/1ps
`default_nettype none
`include "adc_cfg_map.vh"
module adc_channel_config_registers_tb_top;
   localparam [7:0] a_mode = 8'h08, a_clk = 8'h0C, a_gain = 8'h10;
   localparam [7:0] a_stat = 8'h20, a_mask = 8'h24;
   logic ref_clk_in = 1'b0, arst_n_in = 1'b0, data_read_in = 1'b0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, d;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic [5:0] kick = 6'h00;
   logic [1:0] r;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   wire s_axi_rvalid, irq_out, crystal_osc_off_out;
   wire conversion_ready_pin_out, conversion_ready_pin_oe_out;
   wire external_reference_on_out;
   wire [1:0] s_axi_bresp, s_axi_rresp, power_mode_select_out;
   wire [31:0] s_axi_rdata;
   wire [5:0] channel_done_in, channel_enable_out;
   wire [2:0] oversampling_ratio_out, gain_code_ch0_out;
   wire [2:0] gain_code_ch1_out, gain_code_ch2_out, gain_code_ch3_out;
   wire [13:0] oversampling_factor_out;
   integer error_cnt = 0, num_checks = 0;
   // design and modulator model
   adc_channel_config_registers u_dut (.ref_clk_in, .arst_n_in,
      .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
      .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
      .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
      .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
      .s_axi_rresp, .channel_done_in, .data_read_in,
      .conversion_ready_pin_out, .conversion_ready_pin_oe_out,
      .channel_enable_out, .crystal_osc_off_out,
      .external_reference_on_out, .oversampling_ratio_out,
      .oversampling_factor_out, .power_mode_select_out,
      .gain_code_ch0_out, .gain_code_ch1_out, .gain_code_ch2_out,
      .gain_code_ch3_out, .irq_out);
   modulator_model u_mod (.ref_clk_in, .arst_n_in, .kick_in(kick),
      .done_out(channel_done_in));
   // 200 MHz
   always #2.5 ref_clk_in = ~ref_clk_in;
   task finish_test;
      begin
         $display("errors %0d checks %0d", error_cnt, num_checks);
         if (error_cnt == 0 && num_checks > 0)
            $display("Testbench passed");
         else
            $display("Testbench failed");
         $finish;
      end
   endtask
   task chk(input [31:0] got, input [31:0] exp);
      begin
         num_checks = num_checks + 1;
         if (got !== exp) begin
            error_cnt = error_cnt + 1;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
         end
      end
   endtask
   // sampled at the edge, before that edge's updates land
   task wr(input [7:0] a, input [31:0] v);
      reg aw, w;
      begin
         aw = 1'b0;
         w = 1'b0;
         s_axi_awaddr <= a;
         s_axi_wdata <= v;
         s_axi_awvalid <= 1'b1;
         s_axi_wvalid <= 1'b1;
         while (!(aw && w)) begin
            @(posedge ref_clk_in);
            if (!aw && s_axi_awready) begin
               aw = 1'b1;
               s_axi_awvalid <= 1'b0;
            end
            if (!w && s_axi_wready) begin
               w = 1'b1;
               s_axi_wvalid <= 1'b0;
            end
         end
         s_axi_bready <= 1'b1;
         @(posedge ref_clk_in);
         while (!s_axi_bvalid) @(posedge ref_clk_in);
         r = s_axi_bresp;
         s_axi_bready <= 1'b0;
      end
   endtask
   task rd(input [7:0] a);
      begin
         s_axi_araddr <= a;
         s_axi_arvalid <= 1'b1;
         @(posedge ref_clk_in);
         while (!s_axi_arready) @(posedge ref_clk_in);
         s_axi_arvalid <= 1'b0;
         s_axi_rready <= 1'b1;
         @(posedge ref_clk_in);
         while (!s_axi_rvalid) @(posedge ref_clk_in);
         d = s_axi_rdata;
         r = s_axi_rresp;
         s_axi_rready <= 1'b0;
      end
   endtask
   task cyc(input integer n);
      repeat (n) @(posedge ref_clk_in);
   endtask
   task kick_ch(input integer c);
      begin
         kick <= 6'h01 << c;
         @(posedge ref_clk_in);
         kick <= 6'h00;
      end
   endtask
   task clr;
      begin
         data_read_in <= 1'b1;
         @(posedge ref_clk_in);
         data_read_in <= 1'b0;
      end
   endtask
   task t_reset;
      begin
         rd(a_mode);
         chk(d, 32'h0510);
         rd(a_clk);
         chk(d, 32'h7F0E);
         rd(a_gain);
         chk(d, 32'h0000);
         chk(channel_enable_out, 32'h3F);
         chk(crystal_osc_off_out, 32'h0);
         chk(external_reference_on_out, 32'h0);
         chk(oversampling_ratio_out, 32'h3);
         chk(power_mode_select_out, 32'h2);
      end
   endtask
   task t_clock;
      integer i;
      begin
         wr(a_clk, 32'hFFDF);
         rd(a_clk);
         chk(d, 32'h3FDF);
         chk(channel_enable_out, 32'h3F);
         chk(crystal_osc_off_out, 32'h1);
         chk(external_reference_on_out, 32'h1);
         for (i = 0; i < 8; i = i + 1) begin
            wr(a_clk, i * 4 + i % 4);
            chk(oversampling_ratio_out, i);
            chk(oversampling_factor_out,
                i == 7 ? 32'h3F80 : 32'h80 << i);
            chk(power_mode_select_out, i % 4 > 1 ? 32'h2 : i % 4);
            chk(channel_enable_out, 32'h0);
         end
         wr(a_clk, 32'h7F0E);
      end
   endtask
   task t_gain;
      begin
         wr(a_gain, 32'h7777);
         rd(a_gain);
         chk(d, 32'h7777);
         chk({gain_code_ch3_out, gain_code_ch2_out}, 32'h3F);
         chk({gain_code_ch1_out, gain_code_ch0_out}, 32'h3F);
         wr(a_gain, 32'h3210);
         chk({gain_code_ch3_out, gain_code_ch2_out}, 32'h1A);
         chk({gain_code_ch1_out, gain_code_ch0_out}, 32'h08);
      end
   endtask
   // unmapped: error, no data
   task t_bad;
      begin
         rd(8'h30);
         chk(r, `RESP_SLVERR);
         chk(d, 32'h0);
         wr(8'h34, 32'hFFFF);
         chk(r, `RESP_SLVERR);
      end
   endtask
   task t_ready;
      integer n;
      begin
         wr(a_mask, 32'h40);
         wr(a_mode, 32'h051D);
         kick_ch(0);
         for (n = 0; conversion_ready_pin_out !== 1'b0 && n < 20; n++)
            @(posedge ref_clk_in);
         for (n = 0; conversion_ready_pin_out === 1'b0; n++)
            @(posedge ref_clk_in);
         chk(n, `READY_PULSE_CYCLES);
         chk(irq_out, 32'h1);
         rd(a_stat);
         chk(d, 32'h41);
         cyc(1);
         chk(irq_out, 32'h0);
         clr;
         wr(a_mask, 32'h0);
         wr(a_mode, 32'h0518);
         kick_ch(1);
         cyc(12);
         chk(conversion_ready_pin_out, 32'h0);
         chk(irq_out, 32'h0);
         clr;
         cyc(2);
         chk({conversion_ready_pin_oe_out, conversion_ready_pin_out},
             32'h3);
         rd(a_stat);
         chk(d, 32'h42);
         wr(a_clk, 32'h030E);
         wr(a_mode, 32'h0510);
         kick_ch(0);
         cyc(12);
         chk(conversion_ready_pin_out, 32'h1);
         kick_ch(1);
         cyc(12);
         chk(conversion_ready_pin_out, 32'h0);
         clr;
         wr(a_mode, 32'h0514);
         kick_ch(2);
         cyc(4);
         chk(conversion_ready_pin_out, 32'h1);
         kick_ch(0);
         cyc(5);
         chk(conversion_ready_pin_out, 32'h0);
         cyc(10);
         chk(conversion_ready_pin_out, 32'h1);
         clr;
         wr(a_mode, 32'h0512);
         cyc(2);
         chk(conversion_ready_pin_oe_out, 32'h0);
         wr(a_clk, 32'h7F0E);
      end
   endtask
   // main sequence
   initial begin
      repeat (4) @(posedge ref_clk_in);
      arst_n_in <= 1'b1;
      @(posedge ref_clk_in);
      t_reset;
      t_clock;
      t_gain;
      t_bad;
      t_ready;
      finish_test;
   end
   // many times the tests' length
   initial begin
      #100000;
      error_cnt = error_cnt + 1;
      finish_test;
   end
endmodule
`default_nettype wire
